//--- inc/bfd_pkg.sv
// Purpose: Constants and carriers for the bridge fault and delay status bank
// Assumes: Single clock domain, register port is a plain read strobe
// Notes:   Reserved bits are held at zero by masks below
package bfd_pkg;

    localparam int         ADDR_W = 7;
    localparam int         DATA_W = 16;
    localparam int         CNT_W  = 6;

    localparam logic [6:0] FAULT_ADDR   = 7'h52;
    localparam logic [6:0] BRIDGE1_ADDR = 7'h53;
    localparam logic [6:0] BRIDGE2_ADDR = 7'h54;

    // Field positions
    localparam int DRAIN_OV_LSB   = 0;
    localparam int BRAKE_OV_LSB   = 8;
    localparam int BRIDGE_BRK_BIT = 12;
    localparam int INT_BRK_BIT    = 13;
    localparam int OVERCUR_BIT    = 14;
    localparam int TURN_ON_LSB    = 0;
    localparam int TURN_OFF_LSB   = 8;

    // Implemented bits; everything else reads zero
    localparam logic [15:0] FAULT_MASK = 16'h773F;
    localparam logic [15:0] DELAY_MASK = 16'h3F3F;

    localparam logic [15:0] FAULT_RESET = 16'h0000;
    localparam logic [5:0]  COUNT_RESET = 6'h00;
    localparam logic [15:0] RDATA_RESET = 16'h0000;

    // Weight of one delay count, picoseconds
    localparam int DELAY_LSB_PS = 53300;

    typedef struct packed {
        logic [5:0] drain_ov;
        logic [2:0] brake_ov;
        logic       bridge_supply_brake_flag;
        logic       internal_supply_brake_flag;
        logic       sense_amp_overcurrent_flag;
    } bfd_fault_ev_s;

    typedef struct packed {
        logic       valid;
        logic [5:0] turn_on;
        logic [5:0] turn_off;
    } bfd_delay_meas_s;

    typedef struct packed {
        logic [15:0] fault;
        logic [5:0]  b1_on;
        logic [5:0]  b1_off;
        logic [5:0]  b2_on;
        logic [5:0]  b2_off;
        logic [15:0] rd_data;
        logic        rd_valid;
    } bfd_state_s;

endpackage : bfd_pkg

//--- core/bfd_status_regs.sv
// Purpose: Latched fault flags and measured switch delay registers
// Assumes: Host read port decoded from the serial frame elsewhere
// Notes:   Read data is registered, valid one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none

module bfd_status_regs (
    input  wire logic                    sys_clk,
    input  wire logic                    resetn,
    input  wire logic                    soft_reset,
    input  wire logic                    restart,
    input  wire bfd_pkg::bfd_fault_ev_s  fault_ev,
    input  wire bfd_pkg::bfd_delay_meas_s bridge1_meas,
    input  wire bfd_pkg::bfd_delay_meas_s bridge2_meas,
    input  wire logic                    rd_en,
    input  wire logic [6:0]              rd_addr,
    output logic [15:0]                  rd_data,
    output logic                         rd_valid
);

    bfd_pkg::bfd_state_s s_reg;
    bfd_pkg::bfd_state_s s_next;
    logic [15:0]         ev_word;
    logic                rd_fault;
    logic [15:0]         b1_word;
    logic [15:0]         b2_word;

    always_comb begin
        ev_word = 16'h0000;
        ev_word[bfd_pkg::DRAIN_OV_LSB +: 6] =
            fault_ev.drain_ov;
        ev_word[bfd_pkg::BRAKE_OV_LSB +: 3] =
            fault_ev.brake_ov;
        ev_word[bfd_pkg::BRIDGE_BRK_BIT] =
            fault_ev.bridge_supply_brake_flag;
        ev_word[bfd_pkg::INT_BRK_BIT] =
            fault_ev.internal_supply_brake_flag;
        ev_word[bfd_pkg::OVERCUR_BIT] =
            fault_ev.sense_amp_overcurrent_flag;
    end

    assign rd_fault = rd_en && (rd_addr == bfd_pkg::FAULT_ADDR);

    always_comb begin
        b1_word = 16'h0000;
        b1_word[bfd_pkg::TURN_ON_LSB +: 6]  = s_reg.b1_on;
        b1_word[bfd_pkg::TURN_OFF_LSB +: 6] = s_reg.b1_off;
        b2_word = 16'h0000;
        b2_word[bfd_pkg::TURN_ON_LSB +: 6]  = s_reg.b2_on;
        b2_word[bfd_pkg::TURN_OFF_LSB +: 6] = s_reg.b2_off;
    end

    always_comb begin
        s_next = s_reg;
        // Set beats the read clear, so an event in the read cycle survives
        if (rd_fault) begin
            s_next.fault = ev_word & bfd_pkg::FAULT_MASK;
        end else begin
            s_next.fault = (s_reg.fault | ev_word)
                & bfd_pkg::FAULT_MASK;
        end
        if (bridge1_meas.valid) begin
            s_next.b1_on  = bridge1_meas.turn_on;
            s_next.b1_off = bridge1_meas.turn_off;
        end
        if (bridge2_meas.valid) begin
            s_next.b2_on  = bridge2_meas.turn_on;
            s_next.b2_off = bridge2_meas.turn_off;
        end
        s_next.rd_valid = rd_en;
        s_next.rd_data  = bfd_pkg::RDATA_RESET;
        if (rd_en) begin
            unique case (rd_addr)
                bfd_pkg::FAULT_ADDR: begin
                    s_next.rd_data = s_reg.fault
                        & bfd_pkg::FAULT_MASK;
                end
                bfd_pkg::BRIDGE1_ADDR: begin
                    s_next.rd_data = b1_word
                        & bfd_pkg::DELAY_MASK;
                end
                bfd_pkg::BRIDGE2_ADDR: begin
                    s_next.rd_data = b2_word
                        & bfd_pkg::DELAY_MASK;
                end
                default: begin
                    s_next.rd_data = bfd_pkg::RDATA_RESET;
                end
            endcase
        end
        // Restart keeps every implemented bit; reserved bits are masked
        if (restart) begin
            s_next.fault = s_next.fault & bfd_pkg::FAULT_MASK;
        end
        // Soft reset outranks events, captures and restart
        if (soft_reset) begin
            s_next.fault  = bfd_pkg::FAULT_RESET;
            s_next.b1_on  = bfd_pkg::COUNT_RESET;
            s_next.b1_off = bfd_pkg::COUNT_RESET;
            s_next.b2_on  = bfd_pkg::COUNT_RESET;
            s_next.b2_off = bfd_pkg::COUNT_RESET;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            s_reg.fault    <= bfd_pkg::FAULT_RESET;
            s_reg.b1_on    <= bfd_pkg::COUNT_RESET;
            s_reg.b1_off   <= bfd_pkg::COUNT_RESET;
            s_reg.b2_on    <= bfd_pkg::COUNT_RESET;
            s_reg.b2_off   <= bfd_pkg::COUNT_RESET;
            s_reg.rd_data  <= bfd_pkg::RDATA_RESET;
            s_reg.rd_valid <= 1'b0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign rd_data  = s_reg.rd_data;
    assign rd_valid = s_reg.rd_valid;

    // Checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    a_drain_ov_set: assert property (
        !soft_reset |=> ((s_reg.fault[5:0] & $past(fault_ev.drain_ov))
                         == $past(fault_ev.drain_ov)))
        else $error("drain overvoltage event not latched");

    a_brake_ov_set: assert property (
        !soft_reset && fault_ev.brake_ov != 3'b000
        |=> ((s_reg.fault[10:8] & $past(fault_ev.brake_ov))
             == $past(fault_ev.brake_ov)))
        else $error("brake overvoltage event not latched");

    a_supply_brk_set: assert property (
        !soft_reset && fault_ev.bridge_supply_brake_flag
        |=> s_reg.fault[12])
        else $error("bridge supply brake flag not set");

    a_int_brk_set: assert property (
        !soft_reset && fault_ev.internal_supply_brake_flag
        |=> s_reg.fault[13])
        else $error("internal supply brake flag not set");

    a_overcur_set: assert property (
        !soft_reset && fault_ev.sense_amp_overcurrent_flag
        ##1 !rd_fault && !soft_reset |=> s_reg.fault[14])
        else $error("overcurrent flag lost");

    a_reserved_zero: assert property (
        rd_valid |-> (rd_data & ~(($past(rd_addr) == bfd_pkg::FAULT_ADDR)
                      ? bfd_pkg::FAULT_MASK : bfd_pkg::DELAY_MASK))
                     == 16'h0000
        and (s_reg.fault & ~bfd_pkg::FAULT_MASK) == 16'h0000)
        else $error("reserved bit reads nonzero");

    a_fault_read_clr: assert property (
        rd_fault && !soft_reset
        |=> rd_valid && rd_data == $past(s_reg.fault)
            && s_reg.fault == ($past(ev_word) & bfd_pkg::FAULT_MASK))
        else $error("fault read did not return and clear");

    a_fault_sticky: assert property (
        !rd_fault && !soft_reset
        |=> (s_reg.fault & $past(s_reg.fault)) == $past(s_reg.fault))
        else $error("fault flag dropped without a read");

    a_soft_clear: assert property (
        soft_reset |=> s_reg.fault == 16'h0000 && b1_word == 16'h0000
                       && b2_word == 16'h0000)
        else $error("soft reset left state");

    a_restart_keep: assert property (
        restart && !soft_reset && !bridge1_meas.valid
        |=> $stable(b1_word))
        else $error("restart changed bridge 1 counts");

    a_b1_capture: assert property (
        bridge1_meas.valid && !soft_reset
        |=> s_reg.b1_on == $past(bridge1_meas.turn_on)
            && s_reg.b1_off == $past(bridge1_meas.turn_off))
        else $error("bridge 1 measurement not captured");

    a_b2_read: assert property (
        rd_en && rd_addr == bfd_pkg::BRIDGE2_ADDR
        |=> rd_data == {2'b00, $past(s_reg.b2_off),
                        2'b00, $past(s_reg.b2_on)})
        else $error("bridge 2 read data wrong");

    a_b1_read: assert property (
        rd_en && rd_addr == bfd_pkg::BRIDGE1_ADDR
        |=> rd_data == {2'b00, $past(s_reg.b1_off),
                        2'b00, $past(s_reg.b1_on)})
        else $error("bridge 1 read data wrong");

    // Answer timing: exactly one pulse per strobe, quiet otherwise
    a_rd_answer: assert property (
        rd_en |=> rd_valid)
        else $error("read strobe not answered");

    a_valid_pulse: assert property (
        rd_valid |-> $past(rd_en))
        else $error("read answer without a strobe");

    a_idle_quiet: assert property (
        !rd_en |=> !rd_valid && rd_data == 16'h0000)
        else $error("read port not quiet when idle");

    // Unmapped addresses answer with zero rather than stale data
    a_unmapped_zero: assert property (
        rd_en && rd_addr != bfd_pkg::FAULT_ADDR
        && rd_addr != bfd_pkg::BRIDGE1_ADDR
        && rd_addr != bfd_pkg::BRIDGE2_ADDR
        |=> rd_valid && rd_data == 16'h0000)
        else $error("unmapped read returned data");

    // Field by field, so a swapped lane names its own rule
    a_drain_read: assert property (
        rd_fault |=> rd_data[5:0] == $past(s_reg.fault[5:0]))
        else $error("drain overvoltage bits read wrong");

    a_brake_read: assert property (
        rd_fault |=> rd_data[10:8] == $past(s_reg.fault[10:8]))
        else $error("brake overvoltage bits read wrong");

    a_supply_read: assert property (
        rd_fault |=> rd_data[12] == $past(s_reg.fault[12]))
        else $error("bridge supply brake bit read wrong");

    a_int_read: assert property (
        rd_fault |=> rd_data[13] == $past(s_reg.fault[13]))
        else $error("internal supply brake bit read wrong");

    a_overcur_read: assert property (
        rd_fault |=> rd_data[14] == $past(s_reg.fault[14]))
        else $error("overcurrent bit read wrong");

    // Without a fresh event the read clear must really drop the flag
    a_overcur_clear: assert property (
        rd_fault && !fault_ev.sense_amp_overcurrent_flag
        |=> !s_reg.fault[14])
        else $error("overcurrent flag survived its read");

    // Power-on reset is checked on the first edge it lets go
    a_por_clear: assert property (
        $rose(resetn) |-> s_reg.fault == 16'h0000 && b1_word == 16'h0000
                          && b2_word == 16'h0000 && !rd_valid)
        else $error("power-on reset left state");

    // A read in the soft reset cycle still sees the pre-clear contents
    a_soft_read: assert property (
        soft_reset && rd_fault |=> rd_data == $past(s_reg.fault))
        else $error("soft reset read lost old contents");

    a_soft_counts: assert property (
        soft_reset && (bridge1_meas.valid || bridge2_meas.valid)
        |=> b1_word == 16'h0000 && b2_word == 16'h0000)
        else $error("capture survived soft reset");

    a_restart_fault: assert property (
        restart && !soft_reset && !rd_fault && ev_word == 16'h0000
        |=> $stable(s_reg.fault))
        else $error("restart changed fault flags");

    a_restart_b2: assert property (
        restart && !soft_reset && !bridge2_meas.valid
        |=> $stable(b2_word))
        else $error("restart changed bridge 2 counts");

    a_b2_capture: assert property (
        bridge2_meas.valid && !soft_reset
        |=> s_reg.b2_on == $past(bridge2_meas.turn_on)
            && s_reg.b2_off == $past(bridge2_meas.turn_off))
        else $error("bridge 2 measurement not captured");

    // Reads must not disturb the measured counts
    a_b1_hold: assert property (
        !bridge1_meas.valid && !soft_reset |=> $stable(b1_word))
        else $error("bridge 1 counts moved without a capture");

    a_b2_hold: assert property (
        !bridge2_meas.valid && !soft_reset |=> $stable(b2_word))
        else $error("bridge 2 counts moved without a capture");

    c_fault_read_set: cover property (
        rd_fault && s_reg.fault != 16'h0000);
    c_event_on_read: cover property (
        rd_fault && ev_word != 16'h0000);
    c_restart_hold: cover property (
        restart && s_reg.fault != 16'h0000);
    c_delay_read: cover property (
        rd_en && rd_addr == bfd_pkg::BRIDGE1_ADDR && b1_word != 16'h0000);
    c_soft_on_read: cover property (
        soft_reset && rd_fault && s_reg.fault != 16'h0000);

endmodule : bfd_status_regs

`default_nettype wire

//--- testbench/bfd_host_model.sv
// Purpose: Host side of the register read port, issues read strobes
// Assumes: Caller invokes one task per clock, just after the rising edge
// Notes:   Address lines toggle when idle, so a stale value never decodes
`timescale 1ns/1ps
`default_nettype none

module bfd_host_model (
    output var logic       rd_en,
    output var logic [6:0] rd_addr
);
    initial begin
        rd_en   = 1'b0;
        rd_addr = 7'h00;
    end

    task issue(input logic [6:0] a);
        rd_en   = 1'b1;
        rd_addr = a;
    endtask : issue

    task idle();
        rd_en   = 1'b0;
        rd_addr = ~rd_addr;
    endtask : idle
endmodule : bfd_host_model

`default_nettype wire

//--- testbench/bfd_status_regs_tb_top.sv
// Purpose: Self-checking bench for the fault and delay status bank
// Assumes: Every cycle is driven through cyc, so the shadow stays aligned
// Notes:   Shadow registers predict each read; random mix from xorshift
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    err_total++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end

module bfd_status_regs_tb_top;
    logic                     sys_clk = 1'b0;
    logic                     resetn = 1'b0;
    logic                     soft_reset = 1'b0;
    logic                     restart = 1'b0;
    bfd_pkg::bfd_fault_ev_s   fault_ev = '0;
    bfd_pkg::bfd_delay_meas_s b1_meas = '0;
    bfd_pkg::bfd_delay_meas_s b2_meas = '0;
    logic                     rd_en;
    logic [6:0]               rd_addr;
    logic [15:0]              rd_data;
    logic                     rd_valid;
    logic [15:0]              f_sh = '0, d1_sh = '0, d2_sh = '0, exp_v;
    logic [15:0]              exp_q[$];
    logic                     cur_rd = 1'b0, prev_rd = 1'b0;
    logic [31:0]              seed = 32'h0000_916A;
    logic [31:0]              r, r1, r2, r3;
    int                       err_total = 0;
    int                       samples_checked = 0;

    bfd_status_regs i_dut (.sys_clk(sys_clk), .resetn(resetn),
        .soft_reset(soft_reset), .restart(restart), .fault_ev(fault_ev),
        .bridge1_meas(b1_meas), .bridge2_meas(b2_meas), .rd_en(rd_en),
        .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid));
    bfd_host_model i_host (.rd_en(rd_en), .rd_addr(rd_addr));

    always #50 sys_clk = ~sys_clk;

    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    function logic [15:0] exp_of(input logic [6:0] a);
        case (a)
            bfd_pkg::FAULT_ADDR:   return f_sh;
            bfd_pkg::BRIDGE1_ADDR: return d1_sh;
            bfd_pkg::BRIDGE2_ADDR: return d2_sh;
            default:               return 16'h0000;
        endcase
    endfunction : exp_of

    // One clock of stimulus; the shadow follows the register map
    task cyc(input logic sr, input logic rs, input bfd_pkg::bfd_fault_ev_s ev,
             input bfd_pkg::bfd_delay_meas_s m1,
             input bfd_pkg::bfd_delay_meas_s m2,
             input logic rd, input logic [6:0] a);
        @(posedge sys_clk);
        #1;
        {soft_reset, restart, fault_ev, b1_meas, b2_meas} = {sr, rs, ev, m1, m2};
        prev_rd = cur_rd;
        cur_rd  = rd;
        if (rd) begin
            exp_q.push_back(exp_of(a));
            i_host.issue(a);
        end else begin
            i_host.idle();
        end
        if (sr) begin
            {f_sh, d1_sh, d2_sh} = '0;
        end else begin
            f_sh = (rd && a == bfd_pkg::FAULT_ADDR) ? 16'h0000 : f_sh;
            f_sh |= {1'b0, ev.sense_amp_overcurrent_flag,
                     ev.internal_supply_brake_flag, ev.bridge_supply_brake_flag,
                     1'b0, ev.brake_ov, 2'b00, ev.drain_ov};
            if (m1.valid) d1_sh = {2'b00, m1.turn_off, 2'b00, m1.turn_on};
            if (m2.valid) d2_sh = {2'b00, m2.turn_off, 2'b00, m2.turn_on};
        end
    endtask : cyc

    always @(negedge sys_clk) begin
        if (resetn) begin
            `CHK("rd_valid", prev_rd, rd_valid)
            if (rd_valid === 1'b1) begin
                exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hxxxx;
                `CHK("rd_data", exp_v, rd_data)
            end else begin
                `CHK("idle rd_data", 16'h0000, rd_data)
            end
        end
    end

    task end_sim();
        $display("errors %0d checks %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim

    initial begin
        #(100.0 * 4000);
        err_total++;
        end_sim();
    end

    initial begin
        repeat (10) @(posedge sys_clk);
        #1 resetn = 1'b1;
        // Reset values, including unmapped neighbours
        for (int a = 'h50; a < 'h58; a++) cyc(0, 0, '0, '0, '0, 1, 7'(a));
        // Each fault flag alone, then read twice to see the clear
        for (int i = 0; i < 12; i++) begin
            cyc(0, 0, bfd_pkg::bfd_fault_ev_s'(12'(1 << i)), '0, '0, 0, 0);
            cyc(0, 0, '0, '0, '0, 1, bfd_pkg::FAULT_ADDR);
            cyc(0, 0, '0, '0, '0, 1, bfd_pkg::FAULT_ADDR);
        end
        // Random mix: sparse events, captures, resets and back-to-back reads
        for (int n = 0; n < 400; n++) begin
            r  = xs();
            r1 = xs();
            r2 = xs();
            r3 = xs() & xs() & xs();
            cyc(r[4:0] == 0, r[7:5] == 0, bfd_pkg::bfd_fault_ev_s'(r3[11:0]),
                {r[8], r1[11:0]}, {r[9], r2[11:0]}, r[10],
                r[11] ? r[18:12] : 7'h52 + 7'(r[13:12]));
        end
        // Mid-run power-on reset wipes flags and counts
        cyc(0, 0, '1, '1, '1, 0, 0);
        repeat (2) cyc(0, 0, '0, '0, '0, 0, 0);
        resetn = 1'b0;
        {f_sh, d1_sh, d2_sh} = '0;
        repeat (2) cyc(0, 0, '0, '0, '0, 0, 0);
        resetn = 1'b1;
        for (int a = 'h52; a < 'h55; a++) cyc(0, 0, '0, '0, '0, 1, 7'(a));
        repeat (3) cyc(0, 0, '0, '0, '0, 0, 0);
        `CHK("pending answers", 0, exp_q.size())
        end_sim();
    end
endmodule : bfd_status_regs_tb_top

`default_nettype wire
